// ### include/ldac_pkg.sv
package ldac_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [11:0] LDAC_OFS_CONTROL_MAIN = 12'h000;
   localparam logic [11:0] LDAC_OFS_LEVEL_SELECT = 12'h004;
   localparam logic [7:0]  LDAC_RST_CONTROL_MAIN = 8'h00;
   localparam logic [7:0]  LDAC_RST_LEVEL_SELECT = 8'h00;
   localparam logic [7:0]  LDAC_MASK_CONTROL_MAIN = 8'hED;
   localparam logic [7:0]  LDAC_MASK_LEVEL_SELECT = 8'h1F;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int LDAC_BIT_ON      = 7;
   localparam int LDAC_BIT_LPS     = 6;
   localparam int LDAC_BIT_OE      = 5;
   localparam int LDAC_BIT_PSS_HI  = 3;
   localparam int LDAC_BIT_PSS_LO  = 2;
   localparam int LDAC_BIT_NSS     = 0;
   localparam int LDAC_LEVEL_BITS  = 5;

   localparam logic [4:0] LDAC_CODE_ALL_ONES  = 5'h1F;
   localparam logic [4:0] LDAC_CODE_ALL_ZEROS = 5'h00;

   typedef enum logic [1:0] {
      LDAC_PSRC_SUPPLY   = 2'h0,
      LDAC_PSRC_EXT_PIN  = 2'h1,
      LDAC_PSRC_FIXED_2  = 2'h2,
      LDAC_PSRC_RESERVED = 2'h3
   } ldac_psrc_e;

   // analog switch controls towards the ladder
   typedef struct packed {
      logic       ladder_on;
      logic       pos_connect;
      logic       neg_connect;
      logic [2:0] pos_sel_onehot;
      logic       neg_sel_ext;
      logic       clamp_pos;
      logic       clamp_neg;
      logic [4:0] level_code;
      logic       pin_drive;
   } ldac_analog_s;

endpackage

// ### testbench/ladder_dac_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ladder_dac_control_bench;
   import ldac_pkg::*;
   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic         pin_digital_in, pin_digital_out, pin_digital_oe;
   logic         pin_read_value, pin_driver_oe, pin_driver_out;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata, rd;
   logic [3:0]   pstrb;
   ldac_analog_s analog_ctrl;
   int           error_cnt = 0;
   int           checked = 0;
   localparam logic [11:0] M = LDAC_OFS_CONTROL_MAIN;
   localparam logic [11:0] L = LDAC_OFS_LEVEL_SELECT;
   ldac_ladder_dac_control dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .pin_digital_in, .pin_digital_out,
      .pin_digital_oe, .pin_read_value, .pin_driver_oe, .pin_driver_out,
      .analog_ctrl
   );
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   task stop_test;
      $display("checked %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task t_mask;
      xfer(1'b1, M, 32'hFFFF_FFF7);
      xfer(1'b1, L, 32'hFFFF_FFFF);
      xfer(1'b0, M, 0);
      chk("main", 32'hE5, rd);
      xfer(1'b0, L, 0);
      chk("level", 32'h1F, rd);
      chk("on", 1, analog_ctrl.ladder_on);
      chk("nss", 1, analog_ctrl.neg_sel_ext);
      xfer(1'b0, 12'h008, 0);
      chk("unmapped", 32'h0, {rd[31:1], ~err});
   endtask
   task t_sweep;
      for (int i = 0; i < 3; i++) begin
         xfer(1'b1, M, 32'h80 | (i << 2));
         xfer(1'b1, L, i * 15);
         chk("src", 3'h1 << i, analog_ctrl.pos_sel_onehot);
         chk("code", i * 15, analog_ctrl.level_code);
      end
   endtask
   task t_clamp;
      xfer(1'b1, M, 32'h40);
      xfer(1'b1, L, 32'h1F);
      chk("hi clamp", 1, analog_ctrl.clamp_pos);
      chk("neg end", 0, analog_ctrl.neg_connect);
      xfer(1'b1, M, 32'h00);
      chk("pos end", 0, analog_ctrl.pos_connect);
      xfer(1'b1, L, 32'h00);
      chk("lo clamp", 1, analog_ctrl.clamp_neg);
   endtask
   task t_pin;
      pin_digital_in <= 1'b1;
      pin_digital_oe <= 1'b1;
      pin_digital_out <= 1'b1;
      xfer(1'b1, M, 32'h20);
      repeat (3) @(posedge pclk);
      chk("pin read", 0, pin_read_value);
      chk("pin oe", 0, pin_driver_oe);
      chk("pin out", 0, pin_driver_out);
      xfer(1'b1, M, 32'h00);
      repeat (3) @(posedge pclk);
      chk("pin read", 1, pin_read_value);
      chk("pin oe", 1, pin_driver_oe);
      chk("pin out", 1, pin_driver_out);
   endtask
   task t_reset;
      xfer(1'b1, M, 32'hA0);
      xfer(1'b1, L, 32'h0A);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      xfer(1'b0, L, 0);
      chk("code rst", 0, rd);
      chk("pin rst", 0, analog_ctrl.pin_drive);
      chk("on rst", 0, analog_ctrl.ladder_on);
      chk("lvl rst", 0, analog_ctrl.level_code);
   endtask
   task t_strb;
      pstrb <= 4'hE;
      xfer(1'b1, L, 32'h0A);
      pstrb <= 4'hF;
      chk("strb err", 0, err);
      xfer(1'b0, L, 0);
      chk("strb lvl", 0, rd);
      chk("rd err", 0, err);
      chk("strb code", 0, analog_ctrl.level_code);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {pin_digital_in, pin_digital_out, pin_digital_oe} = '0;
      pstrb = 4'hF;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_mask;
      t_sweep;
      t_clamp;
      t_pin;
      t_reset;
      t_strb;
      stop_test;
   end
   initial begin
      repeat (3000) @(posedge pclk);
      error_cnt++;
      stop_test;
   end
endmodule
bind ldac_ladder_dac_control ldac_chk u_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pin_read_value,
   .pin_driver_oe, .analog_ctrl);
`default_nettype wire

// ### testbench/ldac_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ldac_chk
   import ldac_pkg::*;
(
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [11:0]   paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [3:0]    pstrb,
   input wire logic [31:0]   prdata,
   input wire logic          pin_read_value,
   input wire logic          pin_driver_oe,
   input wire ldac_analog_s  analog_ctrl
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_wr(logic [11:0] a);
      psel && penable && pwrite && pstrb[0] && paddr == a;
   endsequence
   sequence s_rd;
      psel && !penable && !pwrite;
   endsequence
   property p_on;
      s_wr(LDAC_OFS_CONTROL_MAIN) |=> ##1
      analog_ctrl.ladder_on == $past(pwdata[7], 2) &&
      analog_ctrl.neg_sel_ext == $past(pwdata[0], 2) &&
      analog_ctrl.neg_connect == !$past(pwdata[6], 2);
   endproperty
   a_on: assert property (p_on) else $error("control not applied");
   property p_lvl;
      s_wr(LDAC_OFS_LEVEL_SELECT) |=> ##1
      analog_ctrl.level_code == $past(pwdata[4:0], 2);
   endproperty
   a_lvl: assert property (p_lvl) else $error("level not applied");
   property p_pss;
      s_wr(LDAC_OFS_CONTROL_MAIN) |=> ##1
      analog_ctrl.pos_sel_onehot == 3'h1 << $past(pwdata[3:2], 2);
   endproperty
   a_pss: assert property (p_pss) else $error("bad source");
   property p_cp;
      analog_ctrl.clamp_pos == (!analog_ctrl.ladder_on &&
      analog_ctrl.pos_connect && analog_ctrl.level_code == LDAC_CODE_ALL_ONES);
   endproperty
   a_cp: assert property (p_cp) else $error("bad high clamp");
   property p_cn;
      analog_ctrl.clamp_neg == (!analog_ctrl.ladder_on &&
      analog_ctrl.neg_connect && analog_ctrl.level_code == LDAC_CODE_ALL_ZEROS);
   endproperty
   a_cn: assert property (p_cn) else $error("bad low clamp");
   property p_rd;
      analog_ctrl.pin_drive && $past(analog_ctrl.pin_drive) |-> !pin_read_value;
   endproperty
   a_rd: assert property (p_rd) else $error("pin read not zero");
   property p_drv;
      analog_ctrl.pin_drive && $past(analog_ctrl.pin_drive) |-> !pin_driver_oe;
   endproperty
   a_drv: assert property (p_drv) else $error("driver not off");
   property p_z;
      s_rd |=> (paddr == LDAC_OFS_LEVEL_SELECT) ? prdata[31:5] == 27'h0 :
      (prdata[31:8] == 24'h0 && !prdata[4] && !prdata[1]);
   endproperty
   a_z: assert property (p_z) else $error("unused bits set");
endmodule
`default_nettype wire

// ### verilog/ldac_ladder_dac_control.sv
`timescale 1ns/1ps
`default_nettype none
module ldac_ladder_dac_control
   import ldac_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 pin_digital_in,
   input  wire logic                 pin_digital_out,
   input  wire logic                 pin_digital_oe,
   output logic                      pin_read_value,
   output logic                      pin_driver_oe,
   output logic                      pin_driver_out,
   output ldac_pkg::ldac_analog_s    analog_ctrl
);
   import ldac_pkg::*;

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [7:0] dac_control_main;
   logic [7:0] dac_level_select;
   logic [7:0] next_dac_control_main;
   logic [7:0] next_dac_level_select;
   logic       pin_sync1;
   logic       pin_sync2;
   logic       next_pin_read_value;
   logic [31:0] next_prdata;
   ldac_analog_s next_analog;

   logic access;
   logic hit_main;
   logic hit_level;

   assign access    = psel & penable;
   assign hit_main  = (paddr == LDAC_OFS_CONTROL_MAIN);
   assign hit_level = (paddr == LDAC_OFS_LEVEL_SELECT);
   assign pready    = 1'b1;
   assign pslverr   = access & ~(hit_main | hit_level);

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   always_comb begin
      next_dac_control_main = dac_control_main;
      next_dac_level_select = dac_level_select;
      if (access && pwrite && pstrb[0]) begin
         if (hit_main) begin
            // retention across sleep: only writes and reset change it
            next_dac_control_main = pwdata[7:0] & LDAC_MASK_CONTROL_MAIN;
         end
         if (hit_level) begin
            next_dac_level_select = pwdata[7:0] & LDAC_MASK_LEVEL_SELECT;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dac_control_main <= LDAC_RST_CONTROL_MAIN;
         dac_level_select <= LDAC_RST_LEVEL_SELECT;
      end else begin
         dac_control_main <= next_dac_control_main;
         dac_level_select <= next_dac_level_select;
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_comb begin
      next_prdata = prdata;
      if (psel && !penable && !pwrite) begin
         if (paddr == LDAC_OFS_CONTROL_MAIN) begin
            next_prdata = {24'h000000, dac_control_main};
         end else if (paddr == LDAC_OFS_LEVEL_SELECT) begin
            next_prdata = {24'h000000, dac_level_select};
         end else begin
            next_prdata = 32'h00000000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else begin
         prdata <= next_prdata;
      end
   end

   // ---------------------------------------------------------------
   // ladder switch controls
   // ---------------------------------------------------------------
   function automatic logic [2:0] psrc_onehot(input logic [1:0] sel);
      logic [2:0] r;
      r = 3'h0;
      unique case (ldac_psrc_e'(sel))
         LDAC_PSRC_SUPPLY:   r = 3'h1;
         LDAC_PSRC_EXT_PIN:  r = 3'h2;
         LDAC_PSRC_FIXED_2:  r = 3'h4;
         LDAC_PSRC_RESERVED: r = 3'h0;
      endcase
      return r;
   endfunction

   always_comb begin
      logic       on;
      logic       lps;
      logic [4:0] code;
      on   = dac_control_main[LDAC_BIT_ON];
      lps  = dac_control_main[LDAC_BIT_LPS];
      code = dac_level_select[LDAC_LEVEL_BITS-1:0];
      next_analog.ladder_on   = on;
      next_analog.level_code  = code;
      next_analog.pos_connect = lps;
      next_analog.neg_connect = ~lps;
      next_analog.pos_sel_onehot =
         psrc_onehot(dac_control_main[LDAC_BIT_PSS_HI:LDAC_BIT_PSS_LO]);
      next_analog.neg_sel_ext = dac_control_main[LDAC_BIT_NSS];
      next_analog.clamp_pos = ~on & lps
                              & (code == LDAC_CODE_ALL_ONES);
      next_analog.clamp_neg = ~on & ~lps
                              & (code == LDAC_CODE_ALL_ZEROS);
      next_analog.pin_drive = dac_control_main[LDAC_BIT_OE];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_ctrl <= '0;
      end else begin
         analog_ctrl <= next_analog;
      end
   end

   // ---------------------------------------------------------------
   // pin override and digital read
   // ---------------------------------------------------------------
   assign pin_driver_oe  = pin_digital_oe & ~analog_ctrl.pin_drive;
   assign pin_driver_out = pin_digital_out & ~analog_ctrl.pin_drive;

   always_comb begin
      next_pin_read_value = pin_sync2;
      if (analog_ctrl.pin_drive) begin
         next_pin_read_value = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sync1      <= 1'b0;
         pin_sync2      <= 1'b0;
         pin_read_value <= 1'b0;
      end else begin
         pin_sync1      <= pin_digital_in;
         pin_sync2      <= pin_sync1;
         pin_read_value <= next_pin_read_value;
      end
   end

endmodule
`default_nettype wire
